// ---- rtl/vdam_pkg.sv ----
// Package for the valve diagnostic alarm monitor.
// Assumes one clock at 25 MHz and an AHB-Lite master with word accesses.
package vdam_pkg;
    // Register byte offsets; every register is one aligned word.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SHUT_CNT = 8'h04;
    localparam logic [7:0] OFS_SHUT_THR = 8'h08;
    localparam logic [7:0] OFS_SPD_POS = 8'h0C;
    localparam logic [7:0] OFS_SPD_NEG = 8'h10;
    localparam logic [7:0] OFS_SPD_THR_POS = 8'h14;
    localparam logic [7:0] OFS_SPD_THR_NEG = 8'h18;
    localparam logic [7:0] OFS_DEV_THR_POS = 8'h1C;
    localparam logic [7:0] OFS_DEV_THR_NEG = 8'h20;
    localparam logic [7:0] OFS_DEV_WAIT = 8'h24;
    localparam logic [7:0] OFS_TMP_THR_HI = 8'h28;
    localparam logic [7:0] OFS_TMP_THR_LO = 8'h2C;
    localparam logic [7:0] OFS_TMP_WAIT = 8'h30;
    localparam logic [7:0] OFS_VALVE_STAT = 8'h34;
    localparam logic [7:0] OFS_DEV_STAT = 8'h38;
    localparam logic [7:0] OFS_DEVIATION = 8'h3C;
    // Control register bit positions.
    localparam int CTL_EN_SHUT = 0;
    localparam int CTL_EN_SPD = 1;
    localparam int CTL_EN_DEV = 2;
    localparam int CTL_EN_TMP = 3;
    localparam int CTL_EN_STICK = 4;
    localparam int CTL_EN_STROKE = 5;
    localparam int CTL_EN_CYCLE = 6;
    localparam int CTL_EN_ZERO = 7;
    localparam int CTL_SPD_UPDATE = 8;
    localparam int CTL_SPD_CLEAR = 9;
    // Reset values.
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
    localparam logic [15:0] RST_THR_MAX = 16'h7FFF;
    // Lowest signed value, so the low temperature limit starts out of reach.
    localparam logic [15:0] RST_THR_MIN = 16'h8000;
    // Loop current and internal temperature limits, in sensor units.
    localparam logic [15:0] LOW_CURRENT_UA = 16'd3800;
    localparam logic signed [15:0] INT_TEMP_LO_C = -16'sd45;
    localparam logic signed [15:0] INT_TEMP_HI_C = 16'sd85;
    // Timebase tick: one waiting-time unit is 1 ms.
    localparam int TICK_NS = 1_000_000;
    localparam int CLK_NS = 40;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    // Wait-timer state.
    typedef enum logic [1:0] {
        WT_IDLE = 2'b00,
        WT_RUN = 2'b01,
        WT_HIT = 2'b10
    } vdam_wait_e;
    // Measured quantities from the sensor front ends.
    typedef struct packed {
        logic signed [15:0] travel_pct;
        logic signed [15:0] input_pct;
        logic signed [15:0] speed;
        logic signed [15:0] temp;
        logic signed [15:0] int_temp;
        logic [15:0] loop_current_ua;
        logic shut_event;
    } vdam_meas_s;
    // Status inputs computed elsewhere.
    typedef struct packed {
        logic lever_detached;
        logic lever_over_angle;
        logic sensor_link_lost;
        logic ram_fail;
        logic rom_fail;
        logic pilot_drive_out_of_range;
        logic forced_end_position;
        logic simulation_active;
        logic substitute_drive_active;
        logic settings_initialized;
        logic external_adjust_switch_in_use;
        logic stick_exceeded;
        logic stroke_exceeded;
        logic cycle_exceeded;
        logic zero_err_up;
        logic zero_err_down;
    } vdam_sts_s;
endpackage

// ---- rtl/vdam_monitor.sv ----
// Valve diagnostic alarm monitor with an AHB-Lite register slave.
// Assumes sensor inputs come from logic on hclk; pin-level status is
// passed through two flip-flops before use.
// How it works
// - Shut-off alarm when count reaches threshold.
// - Each alarm gated by an enable; the paired flags share one.
// - Positive and negative max speeds, host writable.
// - Update copies captured maxima to reported values.
// - Clear restarts maximum capture from zero.
// - Speed alarm when maximum leaves threshold range.
// - Separate upward and downward speed alarm flags.
// - Deviation alarm only after waiting time elapses.
// - Deviation is travel minus input; positive flag.
// - Negative deviation sets its own flag.
// - Temperature alarm only after waiting time elapses.
// - Separate high and low temperature flags.
// - Angle sensor, RAM and ROM failure flags.
// - Low loop current flag at 3.80 mA or below.
// - Internal temperature outside -45 to +85 flagged.
// - Pilot drive out of range flag.
// - Forced end position flag.
// - Substitute input and drive simulation flags.
// - Settings initialized and adjust switch flags.
// - Device status bits 11 and 12 always read as zero.
// - Up and down zero-travel error flags.
// - Stroke, cycle and stick-slip alarm flags.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module vdam_monitor
    import vdam_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire vdam_meas_s meas,
    input wire vdam_sts_s sts_pin,
    output logic [11:0] valve_alarm,
    output logic [12:0] device_status
);
    // Host registers.
    logic [9:0] ctrl_r;
    logic [31:0] shut_cnt_r;
    logic [31:0] shut_thr_r;
    logic [15:0] spd_pos_r;
    logic [15:0] spd_neg_r;
    logic [15:0] cap_pos_r;
    logic [15:0] cap_neg_r;
    logic signed [15:0] spd_thr_pos_r;
    logic signed [15:0] spd_thr_neg_r;
    logic signed [15:0] dev_thr_pos_r;
    logic signed [15:0] dev_thr_neg_r;
    logic [15:0] dev_wait_r;
    logic signed [15:0] tmp_thr_hi_r;
    logic signed [15:0] tmp_thr_lo_r;
    logic [15:0] tmp_wait_r;
    // Bus address phase capture.
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [31:0] rdata_nxt;
    // Synchronised status pins; stage one is read only by stage two.
    vdam_sts_s sts_s1_r;
    vdam_sts_s sts_s2_r;
    // Timebase tick.
    logic [15:0] tick_cnt_r;
    logic tick_r;
    // Wait timers: index 0..3 = dev+, dev-, temp high, temp low.
    vdam_wait_e wst_r [4];
    logic [15:0] wcnt_r [4];
    logic [3:0] beyond;
    logic [15:0] wlimit [4];
    logic signed [16:0] deviation;
    // Alarm and status flag registers.
    logic [11:0] valve_alarm_r;
    logic [12:0] device_status_r;
    logic [11:0] valve_nxt;
    logic [12:0] device_nxt;
    logic upd_cmd;
    logic clr_cmd;

    // Magnitude of a signed speed sample, as an unsigned 16-bit value.
    function automatic logic [15:0] mag(input logic signed [15:0] v);
        logic [15:0] r;
        r = v[15] ? 16'(-v) : 16'(v);
        return r;
    endfunction

    assign upd_cmd = wr_pend_r && addr_r == OFS_CTRL && hwdata[CTL_SPD_UPDATE];
    assign clr_cmd = wr_pend_r && addr_r == OFS_CTRL && hwdata[CTL_SPD_CLEAR];

    // The slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign valve_alarm = valve_alarm_r;
    assign device_status = device_status_r;

    // Address phase capture; only word writes are acted on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite && hsize == 3'b010;
            addr_r <= haddr[7:0];
        end else begin
            wr_pend_r <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        rdata_nxt = RST_ZERO32;
        case (haddr[7:0])
            OFS_CTRL: rdata_nxt = {22'h0, ctrl_r};
            OFS_SHUT_CNT: rdata_nxt = shut_cnt_r;
            OFS_SHUT_THR: rdata_nxt = shut_thr_r;
            OFS_SPD_POS: rdata_nxt = {16'h0, spd_pos_r};
            OFS_SPD_NEG: rdata_nxt = {16'h0, spd_neg_r};
            OFS_SPD_THR_POS: rdata_nxt = {16'h0, spd_thr_pos_r};
            OFS_SPD_THR_NEG: rdata_nxt = {16'h0, spd_thr_neg_r};
            OFS_DEV_THR_POS: rdata_nxt = {16'h0, dev_thr_pos_r};
            OFS_DEV_THR_NEG: rdata_nxt = {16'h0, dev_thr_neg_r};
            OFS_DEV_WAIT: rdata_nxt = {16'h0, dev_wait_r};
            OFS_TMP_THR_HI: rdata_nxt = {16'h0, tmp_thr_hi_r};
            OFS_TMP_THR_LO: rdata_nxt = {16'h0, tmp_thr_lo_r};
            OFS_TMP_WAIT: rdata_nxt = {16'h0, tmp_wait_r};
            OFS_VALVE_STAT: rdata_nxt = {20'h0, valve_alarm_r};
            OFS_DEV_STAT: rdata_nxt = {19'h0, device_status_r};
            OFS_DEVIATION: rdata_nxt = {{15{deviation[16]}}, deviation};
            default: rdata_nxt = RST_ZERO32;
        endcase
    end

    // Read data registered at the end of the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RST_ZERO32;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // Configuration writes. Command bits are pulses and never stored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= 10'h000;
            shut_thr_r <= RST_ZERO32;
            spd_thr_pos_r <= RST_THR_MAX;
            spd_thr_neg_r <= RST_THR_MAX;
            dev_thr_pos_r <= RST_THR_MAX;
            dev_thr_neg_r <= RST_THR_MAX;
            dev_wait_r <= RST_ZERO16;
            tmp_thr_hi_r <= RST_THR_MAX;
            tmp_thr_lo_r <= RST_THR_MIN;
            tmp_wait_r <= RST_ZERO16;
        end else if (wr_pend_r) begin
            case (addr_r)
                OFS_CTRL: ctrl_r <= {2'b00, hwdata[7:0]};
                OFS_SHUT_THR: shut_thr_r <= hwdata;
                OFS_SPD_THR_POS: spd_thr_pos_r <= hwdata[15:0];
                OFS_SPD_THR_NEG: spd_thr_neg_r <= hwdata[15:0];
                OFS_DEV_THR_POS: dev_thr_pos_r <= hwdata[15:0];
                OFS_DEV_THR_NEG: dev_thr_neg_r <= hwdata[15:0];
                OFS_DEV_WAIT: dev_wait_r <= hwdata[15:0];
                OFS_TMP_THR_HI: tmp_thr_hi_r <= hwdata[15:0];
                OFS_TMP_THR_LO: tmp_thr_lo_r <= hwdata[15:0];
                OFS_TMP_WAIT: tmp_wait_r <= hwdata[15:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Fully-closed counter; a host write overrides a same-cycle event.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shut_cnt_r <= RST_ZERO32;
        end else if (wr_pend_r && addr_r == OFS_SHUT_CNT) begin
            shut_cnt_r <= hwdata;
        end else if (meas.shut_event) begin
            shut_cnt_r <= shut_cnt_r + 32'h1;
        end
    end

    // Per-direction capture of the largest speed seen since the last clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_pos_r <= RST_ZERO16;
            cap_neg_r <= RST_ZERO16;
        end else if (clr_cmd) begin
            cap_pos_r <= RST_ZERO16;
            cap_neg_r <= RST_ZERO16;
        end else if (!meas.speed[15]) begin
            if (mag(meas.speed) > cap_pos_r)
                cap_pos_r <= mag(meas.speed);
        end else begin
            if (mag(meas.speed) > cap_neg_r)
                cap_neg_r <= mag(meas.speed);
        end
    end

    // Reported maxima: host writable, refreshed by update, zeroed by clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spd_pos_r <= RST_ZERO16;
            spd_neg_r <= RST_ZERO16;
        end else if (clr_cmd) begin
            spd_pos_r <= RST_ZERO16;
            spd_neg_r <= RST_ZERO16;
        end else if (upd_cmd) begin
            spd_pos_r <= cap_pos_r;
            spd_neg_r <= cap_neg_r;
        end else if (wr_pend_r && addr_r == OFS_SPD_POS) begin
            spd_pos_r <= hwdata[15:0];
        end else if (wr_pend_r && addr_r == OFS_SPD_NEG) begin
            spd_neg_r <= hwdata[15:0];
        end
    end

    // Status pin synchroniser.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_s1_r <= '0;
            sts_s2_r <= '0;
        end else begin
            sts_s1_r <= sts_pin;
            sts_s2_r <= sts_s1_r;
        end
    end

    // Timebase tick for the waiting times.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= RST_ZERO16;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
            tick_cnt_r <= RST_ZERO16;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h1;
            tick_r <= 1'b0;
        end
    end

    // Deviation and threshold conditions for the four wait timers.
    assign deviation = 17'(meas.travel_pct) - 17'(meas.input_pct);
    assign beyond[0] = deviation > 17'(dev_thr_pos_r);
    assign beyond[1] = -deviation > 17'(dev_thr_neg_r);
    assign beyond[2] = meas.temp > tmp_thr_hi_r;
    assign beyond[3] = meas.temp < tmp_thr_lo_r;
    assign wlimit[0] = dev_wait_r;
    assign wlimit[1] = dev_wait_r;
    assign wlimit[2] = tmp_wait_r;
    assign wlimit[3] = tmp_wait_r;

    // Wait timers: a condition must hold for its waiting time in ticks.
    // Dropping back inside restarts from zero, so short spikes never alarm.
    for (genvar i = 0; i < 4; i++) begin : g_wait
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                wst_r[i] <= WT_IDLE;
                wcnt_r[i] <= RST_ZERO16;
            end else begin
                case (wst_r[i])
                    WT_IDLE: begin
                        wcnt_r[i] <= RST_ZERO16;
                        if (beyond[i])
                            wst_r[i] <= WT_RUN;
                    end
                    WT_RUN: begin
                        if (!beyond[i]) begin
                            wst_r[i] <= WT_IDLE;
                            wcnt_r[i] <= RST_ZERO16;
                        // The first tick may come at once, so one tick more
                        // than the limit is counted before the alarm.
                        // A limit of 0xFFFF therefore never expires.
                        end else if (wlimit[i] == RST_ZERO16
                                || wcnt_r[i] > wlimit[i]) begin
                            wst_r[i] <= WT_HIT;
                        end else if (tick_r) begin
                            wcnt_r[i] <= wcnt_r[i] + 16'h1;
                        end
                    end
                    WT_HIT: begin
                        if (!beyond[i])
                            wst_r[i] <= WT_IDLE;
                    end
                    default: wst_r[i] <= WT_IDLE;
                endcase
            end
        end
    end

    // Next valve alarm flags, each gated by its enable.
    always_comb begin
        valve_nxt = 12'h000;
        valve_nxt[0] = ctrl_r[CTL_EN_STICK] && sts_s2_r.stick_exceeded;
        valve_nxt[1] = ctrl_r[CTL_EN_STROKE] && sts_s2_r.stroke_exceeded;
        valve_nxt[2] = ctrl_r[CTL_EN_CYCLE] && sts_s2_r.cycle_exceeded;
        valve_nxt[3] = ctrl_r[CTL_EN_ZERO] && sts_s2_r.zero_err_up;
        valve_nxt[4] = ctrl_r[CTL_EN_ZERO] && sts_s2_r.zero_err_down;
        valve_nxt[5] = ctrl_r[CTL_EN_SHUT] && shut_cnt_r >= shut_thr_r;
        valve_nxt[6] = ctrl_r[CTL_EN_SPD]
            && 17'(spd_pos_r) > 17'(spd_thr_pos_r);
        valve_nxt[7] = ctrl_r[CTL_EN_SPD]
            && 17'(spd_neg_r) > 17'(spd_thr_neg_r);
        valve_nxt[8] = ctrl_r[CTL_EN_DEV] && wst_r[0] == WT_HIT;
        valve_nxt[9] = ctrl_r[CTL_EN_DEV] && wst_r[1] == WT_HIT;
        valve_nxt[10] = ctrl_r[CTL_EN_TMP] && wst_r[2] == WT_HIT;
        valve_nxt[11] = ctrl_r[CTL_EN_TMP] && wst_r[3] == WT_HIT;
    end

    // Next positioner status flags.
    always_comb begin
        device_nxt = 13'h0000;
        device_nxt[0] = sts_s2_r.lever_detached || sts_s2_r.lever_over_angle
            || sts_s2_r.sensor_link_lost;
        device_nxt[1] = sts_s2_r.ram_fail;
        device_nxt[2] = sts_s2_r.rom_fail;
        device_nxt[3] = meas.loop_current_ua <= LOW_CURRENT_UA;
        device_nxt[4] = meas.int_temp < INT_TEMP_LO_C
            || meas.int_temp > INT_TEMP_HI_C;
        device_nxt[5] = sts_s2_r.pilot_drive_out_of_range;
        device_nxt[6] = sts_s2_r.forced_end_position;
        device_nxt[7] = sts_s2_r.simulation_active;
        device_nxt[8] = sts_s2_r.substitute_drive_active;
        device_nxt[9] = sts_s2_r.settings_initialized;
        device_nxt[10] = sts_s2_r.external_adjust_switch_in_use;
        device_nxt[12:11] = 2'b00;
    end

    // Flags follow their causes level for level, one cycle late.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valve_alarm_r <= 12'h000;
            device_status_r <= 13'h0000;
        end else begin
            valve_alarm_r <= valve_nxt;
            device_status_r <= device_nxt;
        end
    end

    // Checks.
    property p_shut;
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_r[CTL_EN_SHUT] && shut_cnt_r >= shut_thr_r) |=> valve_alarm_r[5];
    endproperty
    a_shut: assert property (p_shut) else $error("shut alarm missing");
    property p_en;
        @(posedge hclk) disable iff (!hresetn)
        !ctrl_r[CTL_EN_DEV] |=> !valve_alarm_r[8] && !valve_alarm_r[9];
    endproperty
    a_en: assert property (p_en) else $error("disabled alarm set");
    property p_upd;
        @(posedge hclk) disable iff (!hresetn)
        (upd_cmd && !clr_cmd) |=> spd_pos_r == $past(cap_pos_r);
    endproperty
    a_upd: assert property (p_upd) else $error("update failed");
    property p_clr;
        @(posedge hclk) disable iff (!hresetn)
        clr_cmd |=> spd_pos_r == 16'h0000 && cap_neg_r == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_wait;
        @(posedge hclk) disable iff (!hresetn)
        $rose(valve_alarm_r[8]) |-> $past(wst_r[0] == WT_HIT)
            && $past(dev_wait_r == RST_ZERO16 || wcnt_r[0] > dev_wait_r);
    endproperty
    a_wait: assert property (p_wait) else $error("early deviation");
    property p_restart;
        @(posedge hclk) disable iff (!hresetn)
        (wst_r[2] == WT_RUN && !beyond[2]) |=> wcnt_r[2] == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_low;
        @(posedge hclk) disable iff (!hresetn)
        meas.loop_current_ua <= LOW_CURRENT_UA |=> device_status_r[3];
    endproperty
    a_low: assert property (p_low) else $error("low current missed");
    property p_drop;
        @(posedge hclk) disable iff (!hresetn)
        !beyond[3] ##1 !beyond[3] |=> !valve_alarm_r[11];
    endproperty
    a_drop: assert property (p_drop) else $error("flag stuck");
    c_dev: cover property (@(posedge hclk) $rose(valve_alarm_r[8]));
    c_tmp: cover property (@(posedge hclk) $rose(valve_alarm_r[10]));
    c_clr: cover property (@(posedge hclk) clr_cmd);
endmodule

// ---- tb/vdam_sensor_model.sv ----
// Sensor front ends and status sources that sit beside the monitor.
// Assumes its tasks are entered just after a rising edge of hclk.
`timescale 1ns/1ps
module vdam_sensor_model
    import vdam_pkg::*;
(
    input wire logic hclk,
    output vdam_meas_s meas,
    output vdam_sts_s sts_pin
);
    // Everything starts at zero, like a front end fresh from power-up.
    initial begin
        meas = '0;
        sts_pin = '0;
    end
    // Travel, input signal and stem speed hold until set again.
    task automatic set_motion(input int trv, input int inp, input int spd);
        meas.travel_pct <= 16'(trv);
        meas.input_pct <= 16'(inp);
        meas.speed <= 16'(spd);
    endtask
    // Process temperature, internal temperature and loop current in uA.
    task automatic set_env(input int tmp, input int itmp, input int cur);
        meas.temp <= 16'(tmp);
        meas.int_temp <= 16'(itmp);
        meas.loop_current_ua <= 16'(cur);
    endtask
    // Status levels are asynchronous to the monitor in the real device.
    task automatic set_status(input vdam_sts_s s);
        sts_pin <= s;
    endtask
    // One closure is one pulse of one cycle; a gap cycle keeps them apart.
    task automatic close_valve();
        meas.shut_event <= 1'b1;
        @(posedge hclk);
        meas.shut_event <= 1'b0;
        @(posedge hclk);
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the valve diagnostic alarm monitor.
// Assumes a zero-wait AHB-Lite slave and the sensor model beside it.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
    import vdam_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, d, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp;
    vdam_meas_s meas;
    vdam_sts_s sts_pin, s;
    logic [11:0] valve_alarm;
    logic [12:0] device_status;
    int err_total, checks, shut_n, n, cur, it;
    int spd_q[$]; // Every speed driven since the last clear.
    // The slave's hreadyout is the bus's hready, as on a one-slave bus.
    vdam_monitor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .meas(meas),
        .sts_pin(sts_pin), .valve_alarm(valve_alarm),
        .device_status(device_status));
    vdam_sensor_model sm (.hclk(hclk), .meas(meas), .sts_pin(sts_pin));
    // 25 MHz clock.
    always #20 hclk = ~hclk;
    // One transfer: address phase held until hready, then data phase.
    task automatic ahb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        ahb(1'b1, a, v, x);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    // Largest magnitude seen in one direction since the last clear.
    function automatic int peak(input int sgn);
        int m;
        m = 0;
        foreach (spd_q[i]) if (spd_q[i] * sgn > m) m = spd_q[i] * sgn;
        return m;
    endfunction
    // Drives a speed for a few cycles and remembers it.
    task automatic move(input int v);
        sm.set_motion(0, 0, v);
        spd_q.push_back(v);
        cyc(4);
    endtask
    // Expected minor and major failure flags.
    function automatic logic [12:0] exp_dev(vdam_sts_s t, int c, int m);
        return {2'b00, t.external_adjust_switch_in_use,
            t.settings_initialized, t.substitute_drive_active,
            t.simulation_active, t.forced_end_position,
            t.pilot_drive_out_of_range, logic'(m < -45 || m > 85),
            logic'(c <= 3800), t.rom_fail, t.ram_fail,
            t.lever_detached | t.lever_over_angle | t.sensor_link_lost};
    endfunction
    // Expected alarms when only the externally computed ones may be on.
    function automatic logic [11:0] exp_alm(vdam_sts_s t, logic [7:0] e);
        return {7'h00, e[7] & t.zero_err_down, e[7] & t.zero_err_up,
            e[6] & t.cycle_exceeded, e[5] & t.stroke_exceeded,
            e[4] & t.stick_exceeded};
    endfunction
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog sized well above the longest waiting-time scenario.
    initial begin
        repeat (95000) @(posedge hclk);
        err_total++;
        give_verdict();
    end
    // Main sequence.
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {err_total, checks, shut_n} = '0;
        void'($urandom(73502));
        cyc(16);
        `CHK(valve_alarm, 12'h000)
        hresetn <= 1'b1;
        cyc(1);
        ahb(1'b0, OFS_SHUT_THR, 32'h0, d);
        `CHK(d, 32'h0000_0000)
        ahb(1'b0, OFS_TMP_THR_LO, 32'h0, d);
        `CHK(d, 32'h0000_8000)
        ahb(1'b0, 8'h40, 32'h0, d);
        `CHK(d, 32'h0000_0000)
        wr(OFS_SPD_NEG, 32'h0000_0055);
        ahb(1'b0, OFS_SPD_NEG, 32'h0, d);
        `CHK(d, 32'h0000_0055)
        `CHK(hresp, 1'b0)
        // Shut-off count alarm at the threshold exactly, then disabled.
        wr(OFS_SHUT_THR, 32'h0000_0003);
        wr(OFS_SHUT_CNT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 3; i++) begin
            sm.close_valve();
            shut_n++;
            cyc(4);
            `CHK(valve_alarm[5], logic'(shut_n >= 3))
        end
        ahb(1'b0, OFS_SHUT_CNT, 32'h0, d);
        `CHK(d, 32'(shut_n))
        wr(OFS_CTRL, 32'h0000_0000);
        cyc(4);
        `CHK(valve_alarm[5], 1'b0)
        // Speed maxima: capture, update, clear and recapture below limits.
        wr(OFS_SPD_THR_POS, 32'h0000_0064);
        wr(OFS_SPD_THR_NEG, 32'h0000_0064);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CTRL, 32'h0000_0202);
            spd_q.delete();
            move(k ? 90 : 150);
            move(k ? -80 : -120);
            move(0);
            wr(OFS_CTRL, 32'h0000_0102);
            ahb(1'b0, OFS_SPD_POS, 32'h0, d);
            `CHK(d, 32'(peak(1)))
            ahb(1'b0, OFS_SPD_NEG, 32'h0, d);
            `CHK(d, 32'(peak(-1)))
            cyc(4);
            `CHK(valve_alarm[7:6], (k ? 2'b00 : 2'b11))
        end
        // Deviation both ways with no waiting time, then with one tick.
        wr(OFS_DEV_THR_POS, 32'h0000_0014);
        wr(OFS_DEV_THR_NEG, 32'h0000_0014);
        wr(OFS_DEV_WAIT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0004);
        sm.set_motion(50, 10, 0);
        cyc(6);
        `CHK(valve_alarm[9:8], 2'b01)
        ahb(1'b0, OFS_DEVIATION, 32'h0, d);
        `CHK(d, 32'(50 - 10))
        sm.set_motion(10, 60, 0);
        cyc(6);
        `CHK(valve_alarm[9:8], 2'b10)
        ahb(1'b0, OFS_DEVIATION, 32'h0, d);
        `CHK(d, 32'(10 - 60))
        sm.set_motion(0, 0, 0);
        wr(OFS_DEV_WAIT, 32'h0000_0001);
        cyc(6);
        `CHK(valve_alarm[9:8], 2'b00)
        sm.set_motion(50, 10, 0);
        cyc(TICK_CYC * 4 / 5);
        `CHK(valve_alarm[8], 1'b0)
        n = 0;
        while (valve_alarm[8] !== 1'b1 && n < 2 * TICK_CYC) begin
            cyc(1);
            n++;
        end
        `CHK(valve_alarm[8], 1'b1)
        sm.set_motion(0, 0, 0);
        // Temperature beyond each threshold, then the enable removed.
        wr(OFS_TMP_THR_HI, 32'h0000_003C);
        wr(OFS_TMP_THR_LO, 32'h0000_FFF6);
        wr(OFS_TMP_WAIT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0008);
        sm.set_env(70, 25, 12000);
        cyc(6);
        `CHK(valve_alarm[11:10], 2'b01)
        sm.set_env(-20, 25, 12000);
        cyc(6);
        `CHK(valve_alarm[11:10], 2'b10)
        wr(OFS_CTRL, 32'h0000_0000);
        cyc(4);
        `CHK(valve_alarm[11:10], 2'b00)
        // Random status levels, loop current and internal temperature.
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            s = r[15:0];
            cur = 3790 + int'($urandom % 20);
            it = -50 + int'($urandom % 141);
            wr(OFS_CTRL, {24'h000000, r[23:20], 4'h0});
            sm.set_status(s);
            sm.set_env(0, it, cur);
            cyc(6);
            `CHK(device_status, exp_dev(s, cur, it))
            `CHK(valve_alarm, exp_alm(s, r[23:16]))
        end
        give_verdict();
    end
endmodule
